// File: shared/acm_defines.svh
// constants for the serial-port class handler: request codes, layouts, offsets
// assumes inclusion by bare name; definitions only
//
// Contract
// R1: set-line-coding 0x21/0x20, index 0, length 7; store seven payload bytes.
// R2: payload bytes 0..3 form the 32-bit terminal rate in bits per second.
// R3: byte 4 is stop-bit code 0/1/2; byte 5 parity code 0/1/2.
// R4: byte 6 is data-bit count, valid 5 to 8.
// R5: get-line-coding 0xa1/0x21, value and index 0, length 7 returns seven bytes.
// R6: set-control-lines 0x21/0x22, index 0, length 0, bitmap in value, no data.
// R7: bitmap bit 1 is request-to-send, bit 0 terminal-ready, rest reserved zero.
// R8: control-line request completes with success; no handshake pins driven. The code drives rts_o and dtr_o from the bitmap.
// R9: only serial-state notification 0x20 is ever sent.
// R10: notification header 0xa1, 0x20, value 0, index 0, length 2, then bitmap.
// R11: detect overrun, parity, framing; notify on normal-to-error change.
// R12: no repeated notifications while an error persists.
// R13: bitmap bits: 6 overrun, 5 parity, 4 framing, 3 ring, 2 break, 1 dsr, 0 dcd.
// R14: end each in-transfer with a short packet.
// R15: host reads line coding and sets control lines before data flows.
// R16: data on bulk-in and bulk-out; notifications on a separate interrupt-in.
// R17: unimplemented class requests get a stall.
// R18: line-coding read returns last write, or reset default.
// R19: reserved bitmap bits send zero; reported error bits clear after sending.
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH
`define RT_CLASS_OUT 8'h21
`define RT_CLASS_IN 8'ha1
`define RQ_SET_CODING 8'h20
`define RQ_GET_CODING 8'h21
`define RQ_SET_LINES 8'h22
`define NT_SERIAL_STATE 8'h20
`define CODING_LEN 16'h0007
`define NOTIFY_LEN 16'h0002
`define NOTIFY_BYTES 4'ha
`define DEF_RATE 32'h00002580
`define DEF_STOP 8'h00
`define DEF_PARITY 8'h00
`define DEF_BITS 8'h08
`define BIT_OVR 6
`define BIT_PAR 5
`define BIT_FRM 4
`define BIT_RING 3
`define BIT_BRK 2
`define BIT_DSR 1
`define BIT_DCD 0
`define ADR_RATE 8'h00
`define ADR_FORMAT 8'h04
`define ADR_LINES 8'h08
`define ADR_IRQ_STAT 8'h0c
`define ADR_IRQ_MASK 8'h10
`define ADR_PKT 8'h14
`define RST_PKT 7'h40
`endif

// File: shared/acm_pkg.sv
// types for the serial-port class handler
// assumes acm_defines.svh on the include path
package acm_pkg;
   typedef struct packed {
      logic [7:0] req_type;
      logic [7:0] request;
      logic [15:0] value;
      logic [15:0] index;
      logic [15:0] length;
   } setup_t;
   typedef struct packed {
      logic [31:0] rate;
      logic [7:0] stop;
      logic [7:0] parity;
      logic [7:0] bits;
   } coding_t;
   typedef enum logic [4:0] {
      CT_IDLE = 5'b00001,
      CT_RX = 5'b00010,
      CT_TX = 5'b00100,
      CT_STATUS = 5'b01000,
      CT_STALL = 5'b10000
   } ctl_state_t;
   typedef struct packed {
      ctl_state_t ctl;
      logic [2:0] cnt;
      coding_t coding;
      logic [55:0] shadow;
      logic [1:0] lines;
      setup_t setup;
      logic ok;
      logic stall;
      logic [7:0] ep0_data;
      logic ep0_valid;
      logic ep0_last;
      logic [2:0] err_s1;
      logic [2:0] err_s2;
      logic [2:0] err_prev;
      logic [2:0] pend;
      logic [3:0] sig_s1;
      logic [3:0] sig_s2;
      logic nt_busy;
      logic [3:0] nt_idx;
      logic [15:0] nt_map;
      logic [7:0] nt_data;
      logic nt_valid;
      logic nt_last;
      logic bin_valid;
      logic [7:0] bin_data;
      logic bin_last;
      logic [6:0] pkt_cnt;
      logic [6:0] pkt_max;
      logic bin_short;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic ack;
      logic [31:0] dat;
   } state_t;
endpackage

// File: hdl/acm_class_handler.sv
// class-level handler of a serial-port function over usb
// assumes a usb device core that presents decoded setup packets and byte streams
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "acm_defines.svh"
module acm_class_handler
   import acm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // control pipe from device core
   input wire logic setup_valid_i,
   input wire logic [63:0] setup_i,
   input wire logic ep0_rx_valid_i,
   input wire logic [7:0] ep0_rx_data_i,
   input wire logic ep0_tx_ready_i,
   input wire logic status_done_i,
   output logic [7:0] ep0_tx_data_o,
   output logic ep0_tx_valid_o,
   output logic ep0_tx_last_o,
   output logic ep0_ok_o,
   output logic ep0_stall_o,
   // line coding and control lines
   output logic [31:0] rate_o,
   output logic [7:0] stop_o,
   output logic [7:0] parity_o,
   output logic [7:0] bits_o,
   output logic rts_o,
   output logic dtr_o,
   // uart error and line inputs, asynchronous
   input wire logic [2:0] uart_err_i,
   input wire logic [3:0] uart_sig_i,
   // interrupt-in endpoint
   input wire logic int_ready_i,
   output logic [7:0] int_data_o,
   output logic int_valid_o,
   output logic int_last_o,
   // bulk endpoints
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   input wire logic tx_end_i,
   output logic tx_ready_o,
   input wire logic bin_ready_i,
   output logic [7:0] bin_data_o,
   output logic bin_valid_o,
   output logic bin_last_o,
   output logic bin_short_o,
   input wire logic [7:0] bout_data_i,
   input wire logic bout_valid_i,
   output logic bout_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   // interrupt
   output logic irq_o
);
   state_t q, d;
   setup_t s;
   logic [55:0] cur;
   logic [31:0] rd;
   logic [2:0] rise;
   logic wr, rdv;

   assign s = setup_i;
   assign cur = {q.coding.rate[7:0], q.coding.rate[15:8], q.coding.rate[23:16],
                 q.coding.rate[31:24], q.coding.stop, q.coding.parity, q.coding.bits};
   assign wr = cyc_i & stb_i & we_i & ~q.ack;
   assign rdv = cyc_i & stb_i & ~we_i & ~q.ack;
   assign rise = q.err_s2 & ~q.err_prev; // R11 R12

   always_comb
   begin
      d = q;
      d.ok = 1'b0;
      d.ack = 1'b0;
      d.err_s1 = uart_err_i;
      d.err_s2 = q.err_s1;
      d.err_prev = q.err_s2;
      d.sig_s1 = uart_sig_i;
      d.sig_s2 = q.sig_s1;
      d.pend = q.pend | rise; // R11
      d.irq_stat = q.irq_stat | rise;
      rd = 32'h00000000;
      // control pipe
      case (q.ctl)
         CT_IDLE:
         begin
            d.cnt = 3'h0;
            d.stall = 1'b0;
            if (setup_valid_i)
            begin
               d.setup = s;
               if (s.req_type == `RT_CLASS_OUT && s.request == `RQ_SET_CODING && s.index == 16'h0000
                   && s.length == `CODING_LEN) // R1
                  d.ctl = CT_RX;
               else if (s.req_type == `RT_CLASS_IN && s.request == `RQ_GET_CODING && s.value == 16'h0000
                        && s.index == 16'h0000 && s.length == `CODING_LEN) // R5
               begin
                  d.ctl = CT_TX;
                  d.shadow = cur; // R18
                  // first byte goes out with the state change, so the host sees it one cycle after setup
                  d.ep0_valid = 1'b1;
                  d.ep0_data = cur[55:48]; // R5
                  d.ep0_last = 1'b0;
               end
               else if (s.req_type == `RT_CLASS_OUT && s.request == `RQ_SET_LINES && s.index == 16'h0000
                        && s.length == 16'h0000) // R6
               begin
                  d.lines = s.value[1:0]; // R7
                  d.ctl = CT_STATUS; // R8
               end
               else
               begin
                  d.stall = 1'b1; // R17
                  d.ctl = CT_STALL;
               end
            end
         end
         CT_RX:
            if (ep0_rx_valid_i)
            begin
               d.shadow = {q.shadow[47:0], ep0_rx_data_i}; // R1
               d.cnt = q.cnt + 3'h1;
               if (q.cnt == 3'h6)
               begin
                  d.coding.rate = {q.shadow[23:16], q.shadow[31:24], q.shadow[39:32], q.shadow[47:40]}; // R2
                  d.coding.stop = q.shadow[15:8]; // R3
                  d.coding.parity = q.shadow[7:0]; // R3
                  d.coding.bits = ep0_rx_data_i; // R4
                  d.ctl = CT_STATUS;
               end
            end
         CT_TX:
         begin
            d.ep0_valid = 1'b1;
            d.ep0_data = q.shadow[55:48]; // R5
            d.ep0_last = (q.cnt == 3'h6);
            if (q.ep0_valid && ep0_tx_ready_i)
            begin
               d.shadow = {q.shadow[47:0], 8'h00};
               d.ep0_data = q.shadow[47:40];
               d.cnt = q.cnt + 3'h1;
               d.ep0_last = (q.cnt == 3'h5);
               if (q.ep0_last)
               begin
                  d.ep0_valid = 1'b0;
                  d.ep0_last = 1'b0;
                  d.ctl = CT_STATUS;
               end
            end
         end
         CT_STATUS:
            if (status_done_i)
            begin
               d.ok = 1'b1; // R8
               d.ctl = CT_IDLE;
            end
         CT_STALL:
            if (setup_valid_i)
            begin
               // a new setup ends the stall; it is dropped, host resends
               d.stall = 1'b0; // R17
               d.ctl = CT_IDLE;
            end
            else
               d.stall = 1'b1;
         default:
            d.ctl = CT_IDLE;
      endcase
      // serial-state notification on interrupt-in
      if (!q.nt_busy && q.pend != 3'h0)
      begin
         d.nt_busy = 1'b1;
         d.nt_idx = 4'h0;
         d.nt_map = 16'h0000; // R19
         d.nt_map[`BIT_OVR] = q.pend[2]; // R13
         d.nt_map[`BIT_PAR] = q.pend[1];
         d.nt_map[`BIT_FRM] = q.pend[0];
         d.nt_map[`BIT_RING] = q.sig_s2[3];
         d.nt_map[`BIT_BRK] = q.sig_s2[2];
         d.nt_map[`BIT_DSR] = q.sig_s2[1];
         d.nt_map[`BIT_DCD] = q.sig_s2[0];
         d.pend = rise; // R19
      end
      else if (q.nt_busy)
      begin
         d.nt_valid = 1'b1;
         case (q.nt_idx)
            4'h0: d.nt_data = `RT_CLASS_IN; // R10
            4'h1: d.nt_data = `NT_SERIAL_STATE; // R9
            4'h6: d.nt_data = 8'(`NOTIFY_LEN); // R10
            4'h7: d.nt_data = 8'(`NOTIFY_LEN >> 8);
            4'h8: d.nt_data = q.nt_map[7:0];
            4'h9: d.nt_data = q.nt_map[15:8];
            default: d.nt_data = 8'h00;
         endcase
         d.nt_last = (q.nt_idx == `NOTIFY_BYTES - 4'h1);
         if (q.nt_valid && int_ready_i)
         begin
            d.nt_idx = q.nt_idx + 4'h1;
            d.nt_valid = 1'b0;
            if (q.nt_last)
            begin
               d.nt_busy = 1'b0;
               d.nt_last = 1'b0;
            end
         end
      end
      // bulk-in, short packet terminates the transfer
      if (!q.bin_valid || bin_ready_i)
      begin
         d.bin_valid = 1'b0;
         d.bin_last = 1'b0;
         d.bin_short = 1'b0;
         if (q.bin_valid && q.bin_last)
            d.bin_short = (q.pkt_cnt == q.pkt_max - 7'h1); // R14
         if (q.bin_valid)
            d.pkt_cnt = (q.pkt_cnt == q.pkt_max - 7'h1 || q.bin_last) ? 7'h00 : q.pkt_cnt + 7'h1;
         if (tx_valid_i)
         begin
            d.bin_valid = 1'b1; // R16
            d.bin_data = tx_data_i;
            d.bin_last = tx_end_i; // R14
         end
      end
      // wishbone slave
      if (wr)
      begin
         d.ack = 1'b1;
         if ({adr_i[7:2], 2'b00} == `ADR_IRQ_MASK && sel_i[0])
            d.irq_mask = dat_i[2:0];
         else if ({adr_i[7:2], 2'b00} == `ADR_PKT && sel_i[0])
            d.pkt_max = (dat_i[6:0] == 7'h00) ? `RST_PKT : dat_i[6:0];
      end
      else if (rdv)
      begin
         d.ack = 1'b1;
         if ({adr_i[7:2], 2'b00} == `ADR_RATE)
            rd = q.coding.rate;
         else if ({adr_i[7:2], 2'b00} == `ADR_FORMAT)
            rd = {8'h00, q.coding.bits, q.coding.parity, q.coding.stop};
         else if ({adr_i[7:2], 2'b00} == `ADR_LINES)
            rd = {26'h0, q.sig_s2, q.lines};
         else if ({adr_i[7:2], 2'b00} == `ADR_IRQ_STAT)
         begin
            rd = {29'h0, q.irq_stat};
            d.irq_stat = rise; // set wins over read clear
         end
         else if ({adr_i[7:2], 2'b00} == `ADR_IRQ_MASK)
            rd = {29'h0, q.irq_mask};
         else if ({adr_i[7:2], 2'b00} == `ADR_PKT)
            rd = {25'h0, q.pkt_max};
         else
            rd = 32'h00000000; // unmapped reads zero
      end
      if (rdv)
         d.dat = rd;
      d.irq = (d.irq_stat & q.irq_mask) != 3'h0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.ctl <= CT_IDLE;
         q.coding <= '{rate: `DEF_RATE, stop: `DEF_STOP, parity: `DEF_PARITY, bits: `DEF_BITS}; // R18
         q.pkt_max <= `RST_PKT;
      end
      else
         q <= d;
   end

   assign dat_o = q.dat;
   assign ack_o = q.ack;
   assign ep0_tx_data_o = q.ep0_data;
   assign ep0_tx_valid_o = q.ep0_valid;
   assign ep0_tx_last_o = q.ep0_last;
   assign ep0_ok_o = q.ok;
   assign ep0_stall_o = q.stall;
   assign rate_o = q.coding.rate;
   assign stop_o = q.coding.stop;
   assign parity_o = q.coding.parity;
   assign bits_o = q.coding.bits;
   assign rts_o = q.lines[1];
   assign dtr_o = q.lines[0];
   assign int_data_o = q.nt_data;
   assign int_valid_o = q.nt_valid;
   assign int_last_o = q.nt_last;
   // stall source whenever bulk-in holds an unaccepted byte
   assign tx_ready_o = ~q.bin_valid | bin_ready_i;
   assign bin_data_o = q.bin_data;
   assign bin_valid_o = q.bin_valid;
   assign bin_last_o = q.bin_last;
   assign bin_short_o = q.bin_short;
   // bulk-out passes straight through, no buffer
   assign bout_ready_o = 1'b1;
   assign rx_data_o = bout_data_i;
   assign rx_valid_o = bout_valid_i;
   assign irq_o = q.irq;
endmodule

// File: verification/host_model.sv
// host-side sink for the in data stage and the interrupt-in endpoint
// assumes byte streams held until ready; slow mode readies every other cycle
`timescale 1ns/1ps
module host_model (
   // clock and mode
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   // streams from the handler
   input wire logic [7:0] ep0_data_i,
   input wire logic ep0_valid_i,
   input wire logic [7:0] int_data_i,
   input wire logic int_valid_i,
   output logic ep0_ready_o,
   output logic int_ready_o
);
   logic [7:0] ep0_got[$];
   logic [7:0] int_got[$];
   logic ph_q;
   // slow mode stalls both pipes so held bytes get exercised
   assign ep0_ready_o = !slow_i || ph_q;
   assign int_ready_o = !slow_i || ph_q;
   always @(posedge clk_i)
   begin
      ph_q <= rst_i ? 1'b0 : !ph_q;
      if (ep0_valid_i && ep0_ready_o)
         ep0_got.push_back(ep0_data_i);
      if (int_valid_i && int_ready_o)
         int_got.push_back(int_data_i);
   end
endmodule

// File: verification/acm_class_handler_checker.sv
// assertions on the ports of the class handler
// assumes one clock domain, synchronous reset
`timescale 1ns/1ps
module acm_chk (
   // watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ack_o,
   input wire logic setup_valid_i,
   input wire logic [63:0] setup_i,
   input wire logic [7:0] ep0_tx_data_o,
   input wire logic ep0_tx_valid_o,
   input wire logic ep0_tx_ready_i,
   input wire logic ep0_stall_o,
   input wire logic [31:0] rate_o,
   input wire logic rts_o,
   input wire logic dtr_o,
   input wire logic [7:0] int_data_o,
   input wire logic int_valid_o,
   input wire logic int_last_o,
   input wire logic int_ready_i
);
   logic [3:0] n_q;
   logic idle;
   // setups during a stall are dropped, so only judge fresh ones
   assign idle = setup_valid_i && !ep0_stall_o;
   always_ff @(posedge clk_i)
      n_q <= (rst_i || (int_valid_o && int_ready_i && int_last_o)) ? 4'h0 : n_q + 4'(int_valid_o && int_ready_i);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   a_lines_update: assert property (idle && setup_i[63:48] == 16'h2122 |=> {rts_o, dtr_o} == $past(setup_i[33:32]))
      else $error("control lines not taken");
   a_get_answer: assert property (idle && setup_i[63:48] == 16'ha121 |=> ep0_tx_valid_o && ep0_tx_data_o == rate_o[7:0])
      else $error("line coding read wrong");
   a_stall_unsup: assert property (idle && setup_i[55:48] inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h23} ##1 1 |=> ep0_stall_o)
      else $error("no stall");
   a_stall_hold: assert property (ep0_stall_o && !setup_valid_i |=> ep0_stall_o)
      else $error("stall dropped");
   a_ep0_hold: assert property (ep0_tx_valid_o && !ep0_tx_ready_i |=> ep0_tx_valid_o && $stable(ep0_tx_data_o))
      else $error("data stage byte lost");
   a_int_header: assert property (int_valid_o && !n_q[3] |-> int_data_o == (n_q == 4'h0 ? 8'ha1 : n_q == 4'h1 ? 8'h20 : n_q == 4'h6 ? 8'h02 : 8'h00))
      else $error("notify header wrong");
   a_int_frame: assert property (int_last_o |-> int_valid_o && n_q == 4'h9)
      else $error("notify length wrong");
   a_int_reserved: assert property (int_valid_o && n_q[3] |-> (n_q[0] ? int_data_o : {int_data_o[7], 7'h00}) == 8'h00)
      else $error("reserved map bits set");
   cover property (int_last_o && int_ready_i);
   cover property ($rose(ep0_stall_o));
   cover property ($rose(rts_o));
endmodule
bind acm_class_handler acm_chk chk_u (.*);

// File: verification/acm_class_handler_test.sv
// self-checking bench for the class handler
// assumes host_model as sink and the bound checker
`timescale 1ns/1ps
module acm_class_handler_test;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, setup_valid_i, ep0_rx_valid_i, status_done_i, bin_ready_i, slow;
   logic ep0_tx_ready_i, int_ready_i, ack_o, ep0_tx_valid_o, ep0_tx_last_o, ep0_ok_o, ep0_stall_o;
   logic rts_o, dtr_o, int_valid_o, int_last_o, irq_o;
   logic [7:0] adr_i, ep0_rx_data_i, ep0_tx_data_o, stop_o, parity_o, bits_o, int_data_o;
   logic [3:0] sel_i, uart_sig_i;
   logic [2:0] uart_err_i;
   logic [31:0] dat_i, dat_o, rate_o, rdat;
   logic [63:0] setup_i;
   logic tx_valid_i, tx_end_i, bout_valid_i, tx_ready_o, bin_valid_o, bin_last_o, bin_short_o, bout_ready_o, rx_valid_o;
   logic [7:0] tx_data_i, bin_data_o, bout_data_i, rx_data_o;
   logic [7:0] hdr [10] = '{8'ha1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
   logic [7:0] code [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h23};
   int n_mismatch, checks;
   acm_class_handler dut_u (.*);
   host_model hm (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ep0_data_i(ep0_tx_data_o),
      .ep0_valid_i(ep0_tx_valid_o), .int_data_i(int_data_o), .int_valid_i(int_valid_o),
      .ep0_ready_o(ep0_tx_ready_i), .int_ready_o(int_ready_i));
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
      begin
         n_mismatch++;
         $display("wrong value at %0t: no bus ack", $time);
      end
      rdat = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task req(input logic [63:0] s);
      @(posedge clk_i);
      {setup_valid_i, setup_i} <= {1'b1, s};
      @(posedge clk_i);
      setup_valid_i <= 1'b0;
   endtask
   task wait_neg(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // ok is a one-cycle pulse, so poll every cycle
   task status;
      int n;
      @(posedge clk_i);
      status_done_i <= 1'b1;
      @(posedge clk_i);
      status_done_i <= 1'b0;
      n = 0;
      while (ep0_ok_o !== 1'b1 && n < 8)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(ep0_ok_o, 1'b1, "status ok");
   endtask
   task get(input logic [55:0] c);
      int n;
      hm.ep0_got.delete();
      req({8'ha1, 8'h21, 48'h7});
      n = 0;
      while (hm.ep0_got.size() < 7 && n < 40)
      begin
         @(negedge clk_i);
         n++;
      end
      for (int i = 0; i < 7; i++)
         chk(hm.ep0_got[i], c[8*i+:8], "coding byte");
      status();
   endtask
   task lines(input logic [1:0] v);
      req({8'h21, 8'h22, 14'h0, v, 32'h0});
      wait_neg(1);
      chk({rts_o, dtr_o}, v, "control lines");
      status();
   endtask
   task note(input logic [2:0] e);
      int n;
      hm.int_got.delete();
      @(posedge clk_i);
      uart_err_i <= 3'b000;
      repeat (8) @(posedge clk_i);
      uart_err_i <= e;
      n = 0;
      while (hm.int_got.size() < 10 && n < 200)
      begin
         @(negedge clk_i);
         n++;
      end
      for (int i = 0; i < 10; i++)
         chk(hm.int_got[i], i == 8 ? {1'b0, e, uart_sig_i} : hdr[i], "notify byte");
   endtask
   task t_enum;
      get({8'h08, 8'h00, 8'h00, 32'h00002580});
      lines(2'b10);
      lines(2'b01);
      $display("test enum done");
   endtask
   task t_coding;
      logic [55:0] c;
      for (int i = 0; i < 4; i++)
      begin
         c = {8'h05 + 8'(i), 8'(i % 3), 8'(i % 3), 32'h0001c200 + 32'(i)};
         slow <= i[0];
         req({8'h21, 8'h20, 48'h7});
         for (int k = 0; k < 7; k++)
         begin
            @(posedge clk_i);
            {ep0_rx_valid_i, ep0_rx_data_i} <= {1'b1, c[8*k+:8]};
         end
         @(posedge clk_i);
         ep0_rx_valid_i <= 1'b0;
         status();
         chk(rate_o, c[31:0], "rate");
         chk({parity_o, stop_o}, c[47:32], "stop parity");
         chk(bits_o, c[55:48], "data bits");
         get(c);
      end
      slow <= 1'b0;
      wb(1'b0, 8'h04, 32'h0);
      chk(rdat, {8'h00, c[55:32]}, "format reg");
      $display("test coding done");
   endtask
   task t_stall;
      for (int i = 0; i < 6; i++)
      begin
         req({(code[i] == 8'h01 || code[i] == 8'h03) ? 8'ha1 : 8'h21, code[i], 48'h0});
         wait_neg(2);
         chk(ep0_stall_o, 1'b1, "stall");
         req({8'ha1, 8'h21, 48'h7});
         wait_neg(2);
         chk(ep0_stall_o, 1'b0, "stall cleared");
      end
      $display("test stall done");
   endtask
   task t_notify;
      wb(1'b1, 8'h10, 32'h7);
      note(3'b010);
      chk(irq_o, 1'b1, "irq raised");
      wait_neg(60);
      chk(hm.int_got.size(), 32'd10, "single notify");
      wb(1'b0, 8'h0c, 32'h0);
      chk(rdat, 32'h2, "irq status");
      note(3'b100);
      wb(1'b1, 8'h10, 32'h0);
      wait_neg(2);
      chk(irq_o, 1'b0, "irq masked");
      note(3'b001);
      chk(irq_o, 1'b0, "irq still masked");
      wb(1'b0, 8'h0c, 32'h0);
      chk(rdat, 32'h5, "sticky status");
      wb(1'b0, 8'h20, 32'h0);
      chk(rdat, 32'h0, "unmapped read");
      $display("test notify done");
   endtask
   task t_bulk;
      wb(1'b1, 8'h14, 32'h4);
      wb(1'b0, 8'h14, 32'h0);
      chk(rdat, 32'h4, "packet size");
      for (int k = 0; k < 9; k++)
      begin
         @(posedge clk_i);
         {tx_valid_i, tx_end_i, bout_valid_i} <= {k < 7, k == 3 || k == 6, k < 7};
         {tx_data_i, bout_data_i} <= {8'(k + 16), 8'(k + 32)};
         @(negedge clk_i);
         chk({bin_valid_o, bin_last_o, bin_short_o}, {k > 0 && k < 8, k == 4 || k == 7, k == 5}, "bulk-in flags");
         if (k > 0 && k < 8)
            chk(bin_data_o, 8'(k + 15), "bulk-in byte");
         chk({rx_valid_o, rx_data_o, bout_ready_o, tx_ready_o}, {k < 7, 8'(k + 32), 2'b11}, "bulk-out byte");
      end
      @(posedge clk_i);
      {bin_ready_i, tx_valid_i} <= 2'b01;
      repeat (2) @(negedge clk_i);
      chk({bin_valid_o, tx_ready_o}, 2'b10, "bulk-in held");
      @(posedge clk_i);
      {bin_ready_i, tx_valid_i} <= 2'b10;
      $display("test bulk done");
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial
   begin
      {cyc_i, stb_i, we_i, setup_valid_i, ep0_rx_valid_i, status_done_i, slow} = '0;
      {adr_i, ep0_rx_data_i, sel_i, dat_i, setup_i, uart_err_i} = '0;
      {tx_valid_i, tx_end_i, bout_valid_i, tx_data_i, bout_data_i} = '0;
      uart_sig_i = 4'h9;
      bin_ready_i = 1'b1;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_enum;
      t_coding;
      t_stall;
      t_notify;
      t_bulk;
      finish_test;
   end
   initial
   begin
      repeat (10000) @(posedge clk_i);
      n_mismatch++;
      finish_test;
   end
endmodule
